// ===== hdl/qpm_pkg.sv
// Package for the quad channel pin function multiplexer.
// Assumes an AXI4-Lite master on a single 25 MHz clock.
package qpm_pkg;
   // Channel modes, one-hot
   typedef enum logic [3:0] {
      QPM_MODE_SERIAL = 4'h1,  // Asynchronous serial port
      QPM_MODE_SYNCBB = 4'h2,  // Synchronous bit-bang
      QPM_MODE_ASYNBB = 4'h4,  // Asynchronous bit-bang
      QPM_MODE_ENGINE = 4'h8   // Sync serial engine
   } qpm_mode_e;
   // Register byte offsets
   localparam logic [7:0] QPM_OFF_MODE = 8'h00;    // Mode and config control
   localparam logic [7:0] QPM_OFF_OUT_AB = 8'h04;  // Output values chan a, b
   localparam logic [7:0] QPM_OFF_OUT_CD = 8'h08;  // Output values chan c, d
   localparam logic [7:0] QPM_OFF_DIR_AB = 8'h0C;  // Bit-bang directions a, b
   localparam logic [7:0] QPM_OFF_DIR_CD = 8'h10;  // Bit-bang directions c, d
   localparam logic [7:0] QPM_OFF_PIN_IN = 8'h14;  // Sampled pins, all channels
   localparam logic [7:0] QPM_OFF_STATUS = 8'h18;  // Status
   // Mode register fields
   localparam int QPM_MODE_W = 2;        // Mode code width per channel
   localparam int QPM_DRVEN_POS = 8;     // Line driver select, 4 bits
   localparam int QPM_WAKEEN_POS = 12;   // Remote wakeup enable
   localparam int QPM_VALID_POS = 16;    // Stored configuration present
   // Mode codes in the mode register
   localparam logic [1:0] QPM_CODE_SERIAL = 2'h0;
   localparam logic [1:0] QPM_CODE_SYNCBB = 2'h1;
   localparam logic [1:0] QPM_CODE_ASYNBB = 2'h2;
   localparam logic [1:0] QPM_CODE_ENGINE = 2'h3;
   // Reset values
   localparam logic [31:0] QPM_MODE_RST = 32'h0000_0000;
   localparam logic [31:0] QPM_ZERO_RST = 32'h0000_0000;
   // AXI responses
   localparam logic [1:0] QPM_RESP_OKAY = 2'h0;
   localparam logic [1:0] QPM_RESP_SLVERR = 2'h2;
   // Serial pin positions within a channel
   localparam int QPM_PIN_TXD = 0;
   localparam int QPM_PIN_RXD = 1;
   localparam int QPM_PIN_RTS = 2;
   localparam int QPM_PIN_CTS = 3;
   localparam int QPM_PIN_DTR = 4;
   localparam int QPM_PIN_DSR = 5;
   localparam int QPM_PIN_DCD = 6;
   localparam int QPM_PIN_RING = 7;
   // Pin direction masks per role (1 = driven)
   localparam logic [7:0] QPM_OE_SERIAL = 8'h15;     // txd, rts, dtr
   localparam logic [7:0] QPM_OE_SER_DRV = 8'h95;    // plus line driver enable
   localparam logic [7:0] QPM_OE_ENGINE = 8'h0B;     // clock, data out, select
   localparam logic [7:0] QPM_OE_BB_GPIO = 8'hF0;    // Upper lines, direction bits
endpackage

// ===== hdl/qpm_channel.sv
// One channel of the pin function multiplexer: role decode to pin drive.
// Assumes pin inputs already synchronised; outputs are registered here.
`timescale 1ns/1ps
module qpm_channel
   import qpm_pkg::*;
#(
   parameter bit HAS_ENGINE = 1'b0  // Channel owns a sync serial engine
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [1:0] mode_code,   // Mode code from control
   input wire logic cfg_valid,         // Stored configuration present
   input wire logic drv_sel,           // Eighth pin as line driver enable
   input wire logic [7:0] out_val,     // Values to drive
   input wire logic [7:0] dir,         // Direction for bidirectional lines
   input wire logic [7:0] pin_in,      // Synchronised pin levels
   output logic [7:0] pin_out,         // Pin drive values
   output logic [7:0] pin_oe,          // Pin output enables
   output logic ring_n,                // Ring input level while the eighth pin is not driven
   output qpm_mode_e mode              // Effective mode
);
   qpm_mode_e next_mode;  // Decoded mode
   logic [7:0] next_oe;   // Decoded enables

   // Decode effective mode
   always_comb begin
      if (!cfg_valid) begin
         next_mode = QPM_MODE_SERIAL;
      end else begin
         unique case (mode_code)
            QPM_CODE_SYNCBB: next_mode = QPM_MODE_SYNCBB;
            QPM_CODE_ASYNBB: next_mode = QPM_MODE_ASYNBB;
            // Engine only on channels that have one
            QPM_CODE_ENGINE: next_mode = HAS_ENGINE ? QPM_MODE_ENGINE : QPM_MODE_SERIAL;
            default: next_mode = QPM_MODE_SERIAL;
         endcase
      end
   end

   // Pin role enables per mode
   always_comb begin
      unique case (next_mode)
         QPM_MODE_SERIAL: next_oe = (drv_sel && cfg_valid) ? QPM_OE_SER_DRV : QPM_OE_SERIAL;
         QPM_MODE_ENGINE: next_oe = QPM_OE_ENGINE | (dir & QPM_OE_BB_GPIO);
         default: next_oe = dir;
      endcase
   end

   // Registered pin drive
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_out <= 8'h00;
         pin_oe <= QPM_OE_SERIAL;
         mode <= QPM_MODE_SERIAL;
         ring_n <= 1'b1;
      end else begin
         pin_out <= out_val & next_oe;
         pin_oe <= next_oe;
         mode <= next_mode;
         // Ring only seen when the eighth pin is an input
         ring_n <= (next_oe[QPM_PIN_RING]) ? 1'b1 : pin_in[QPM_PIN_RING];
      end
   end
endmodule

// ===== hdl/qpm_top.sv
// Quad channel pin function multiplexer with AXI4-Lite control.
// Assumes one 25 MHz clock; pins arrive asynchronous and are synchronised.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module qpm_top
   import qpm_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Channel pins, three signals each
   input wire logic [7:0] chan_a_pins_in,
   output logic [7:0] chan_a_pins_out,
   output logic [7:0] chan_a_pins_oe,
   input wire logic [7:0] chan_b_pins_in,
   output logic [7:0] chan_b_pins_out,
   output logic [7:0] chan_b_pins_oe,
   input wire logic [7:0] chan_c_pins_in,
   output logic [7:0] chan_c_pins_out,
   output logic [7:0] chan_c_pins_oe,
   input wire logic [7:0] chan_d_pins_in,
   output logic [7:0] chan_d_pins_out,
   output logic [7:0] chan_d_pins_oe,
   // Host side
   input wire logic usb_suspended,   // Host link is in suspend
   output logic resume_request       // Ask host to resume
);
   // Control registers
   logic [31:0] mode_reg;     // Modes, driver selects, wakeup, valid
   logic [31:0] out_ab;       // Output values a, b
   logic [31:0] out_cd;       // Output values c, d
   logic [31:0] dir_ab;       // Directions a, b
   logic [31:0] dir_cd;       // Directions c, d
   // Pin synchronisers
   logic [31:0] pin_meta;     // First stage
   logic [31:0] pin_sync;     // Second stage
   logic susp_meta;           // Suspend first stage
   logic susp_sync;           // Suspend second stage
   // Channel results
   logic [31:0] all_out;      // Pin drive values
   logic [31:0] all_oe;       // Pin enables
   logic [3:0] ring_n;        // Ring levels per channel
   qpm_mode_e mode_ch [4];    // Effective modes
   // Write path state
   logic aw_held;             // Address captured
   logic w_held;              // Data captured
   logic [7:0] aw_addr;       // Captured address
   logic [31:0] w_data;       // Captured data
   logic [3:0] w_strb;        // Captured strobes
   logic next_ring_any;       // Any ring asserted
   logic [31:0] next_rdata;   // Read mux
   logic next_rhit;           // Read address mapped

   // Byte-lane merge
   function automatic logic [31:0] qpm_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Two-flop pin synchronisers
   // Pins and suspend are asynchronous; only the second stage is read
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_meta <= QPM_ZERO_RST;
         pin_sync <= QPM_ZERO_RST;
         susp_meta <= 1'b0;
         susp_sync <= 1'b0;
      end else begin
         pin_meta <= {chan_d_pins_in, chan_c_pins_in, chan_b_pins_in, chan_a_pins_in};
         pin_sync <= pin_meta;
         susp_meta <= usb_suspended;
         susp_sync <= susp_meta;
      end
   end

   // Four channels; only a and b carry an engine
   // Engine code on c or d falls back to serial inside the channel
   qpm_channel #(.HAS_ENGINE(1'b1)) u_chan_a (
      .clock(clock),
      .rst_n(rst_n),
      .mode_code(mode_reg[1:0]),
      .cfg_valid(mode_reg[QPM_VALID_POS]),
      .drv_sel(mode_reg[QPM_DRVEN_POS]),
      .out_val(out_ab[7:0]),
      .dir(dir_ab[7:0]),
      .pin_in(pin_sync[7:0]),
      .pin_out(all_out[7:0]),
      .pin_oe(all_oe[7:0]),
      .ring_n(ring_n[0]),
      .mode(mode_ch[0]));
   qpm_channel #(.HAS_ENGINE(1'b1)) u_chan_b (
      .clock(clock),
      .rst_n(rst_n),
      .mode_code(mode_reg[3:2]),
      .cfg_valid(mode_reg[QPM_VALID_POS]),
      .drv_sel(mode_reg[QPM_DRVEN_POS+1]),
      .out_val(out_ab[15:8]),
      .dir(dir_ab[15:8]),
      .pin_in(pin_sync[15:8]),
      .pin_out(all_out[15:8]),
      .pin_oe(all_oe[15:8]),
      .ring_n(ring_n[1]),
      .mode(mode_ch[1]));
   qpm_channel #(.HAS_ENGINE(1'b0)) u_chan_c (
      .clock(clock),
      .rst_n(rst_n),
      .mode_code(mode_reg[5:4]),
      .cfg_valid(mode_reg[QPM_VALID_POS]),
      .drv_sel(mode_reg[QPM_DRVEN_POS+2]),
      .out_val(out_cd[7:0]),
      .dir(dir_cd[7:0]),
      .pin_in(pin_sync[23:16]),
      .pin_out(all_out[23:16]),
      .pin_oe(all_oe[23:16]),
      .ring_n(ring_n[2]),
      .mode(mode_ch[2]));
   qpm_channel #(.HAS_ENGINE(1'b0)) u_chan_d (
      .clock(clock),
      .rst_n(rst_n),
      .mode_code(mode_reg[7:6]),
      .cfg_valid(mode_reg[QPM_VALID_POS]),
      .drv_sel(mode_reg[QPM_DRVEN_POS+3]),
      .out_val(out_cd[15:8]),
      .dir(dir_cd[15:8]),
      .pin_in(pin_sync[31:24]),
      .pin_out(all_out[31:24]),
      .pin_oe(all_oe[31:24]),
      .ring_n(ring_n[3]),
      .mode(mode_ch[3]));

   // Pin outputs come from the channel flops
   assign chan_a_pins_out = all_out[7:0];
   assign chan_a_pins_oe = all_oe[7:0];
   assign chan_b_pins_out = all_out[15:8];
   assign chan_b_pins_oe = all_oe[15:8];
   assign chan_c_pins_out = all_out[23:16];
   assign chan_c_pins_oe = all_oe[23:16];
   assign chan_d_pins_out = all_out[31:24];
   assign chan_d_pins_oe = all_oe[31:24];

   // Any ring held low
   // Ring counts in any mode that leaves the eighth pin an input
   assign next_ring_any = ~&ring_n;

   // Resume request while suspended, wakeup enabled, ring low
   // Ring passes the synchroniser and the channel flop before this one
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         resume_request <= 1'b0;
      end else begin
         resume_request <= susp_sync && mode_reg[QPM_WAKEEN_POS] && next_ring_any;
      end
   end

   // Write address and data capture, either order
   // Each half waits here until the other arrives; the slot frees
   // at the same edge that commits the register write
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= QPM_ZERO_RST;
         w_strb <= 4'h0;
      end else if (aw_held && w_held) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // Ready while slot free and no response pending
   // Ready drops on its own handshake so a held item is never overwritten
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Register writes and write response
   // Writable bits are masked so reserved fields read back zero
   // Unmapped offsets leave every register untouched and answer an error
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mode_reg <= QPM_MODE_RST;
         out_ab <= QPM_ZERO_RST;
         out_cd <= QPM_ZERO_RST;
         dir_ab <= QPM_ZERO_RST;
         dir_cd <= QPM_ZERO_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= QPM_RESP_OKAY;
      end else if (aw_held && w_held) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= QPM_RESP_OKAY;
         unique case (aw_addr & 8'hFC)
            QPM_OFF_MODE: mode_reg <= qpm_merge(mode_reg, w_data, w_strb) & 32'h0001_1FFF;
            QPM_OFF_OUT_AB: out_ab <= qpm_merge(out_ab, w_data, w_strb) & 32'h0000_FFFF;
            QPM_OFF_OUT_CD: out_cd <= qpm_merge(out_cd, w_data, w_strb) & 32'h0000_FFFF;
            QPM_OFF_DIR_AB: dir_ab <= qpm_merge(dir_ab, w_data, w_strb) & 32'h0000_FFFF;
            QPM_OFF_DIR_CD: dir_cd <= qpm_merge(dir_cd, w_data, w_strb) & 32'h0000_FFFF;
            default: s_axi_bresp <= QPM_RESP_SLVERR;
         endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read decode
   // Low address bits ignored; every register is one aligned word
   always_comb begin
      next_rhit = 1'b1;
      unique case (s_axi_araddr & 8'hFC)
         QPM_OFF_MODE: next_rdata = mode_reg;
         QPM_OFF_OUT_AB: next_rdata = out_ab;
         QPM_OFF_OUT_CD: next_rdata = out_cd;
         QPM_OFF_DIR_AB: next_rdata = dir_ab;
         QPM_OFF_DIR_CD: next_rdata = dir_cd;
         QPM_OFF_PIN_IN: next_rdata = pin_sync;
         QPM_OFF_STATUS: next_rdata = {11'h000, resume_request, ~ring_n,
                                       mode_ch[3], mode_ch[2], mode_ch[1], mode_ch[0]};
         default: begin
            next_rdata = QPM_ZERO_RST;
            next_rhit = 1'b0;
         end
      endcase
   end

   // Read channel
   // One read at a time: arready stays low until the data is taken
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= QPM_ZERO_RST;
         s_axi_rresp <= QPM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rhit ? QPM_RESP_OKAY : QPM_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// ===== testbench/qpm_asserts.sv
// Checker for the pin function multiplexer top, bound to its ports.
// Assumes one clock and a synchronous active low reset.
`timescale 1ns/1ps
module qpm_asserts (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] chan_a_pins_out,
   input wire logic [7:0] chan_a_pins_oe,
   input wire logic usb_suspended,
   input wire logic resume_request
);
   // One domain for every check
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_reset_serial: assert property ($rose(rst_n) |-> chan_a_pins_oe == 8'h15)
      else $error("pins not serial after reset");
   chk_drive_masked: assert property ((chan_a_pins_out & ~chan_a_pins_oe) == 8'h00)
      else $error("value on undriven pin");
   chk_oe_cause: assert property ($changed(chan_a_pins_oe) |-> $past(s_axi_bvalid) ||
      $past(s_axi_bvalid, 2))
      else $error("pin roles changed without a write");
   chk_resume_src: assert property (resume_request |-> $past(usb_suspended, 3))
      else $error("resume without suspend");
   chk_resume_idle: assert property ((!usb_suspended) [*4] |=> !resume_request)
      else $error("resume while awake");
   chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_bresp_hold: assert property (s_axi_bvalid |=> $past(s_axi_bready) ||
      (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("write response dropped");
   chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_rdata_hold: assert property (s_axi_rvalid |=> $past(s_axi_rready) ||
      (s_axi_rvalid && $stable(s_axi_rdata)))
      else $error("read data dropped");
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   // Main scenarios reached
   cover property (s_axi_bvalid && s_axi_bready);
   cover property ($rose(resume_request));
   cover property (chan_a_pins_oe == 8'hAB);
endmodule
bind qpm_top qpm_asserts u_chk (.clock(clock), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .chan_a_pins_out(chan_a_pins_out), .chan_a_pins_oe(chan_a_pins_oe),
   .usb_suspended(usb_suspended), .resume_request(resume_request));

// ===== testbench/qpm_far_side.sv
// Far side of the 32 channel pins: peripherals and loose wires.
// Assumes the bench never drives a pin the block drives.
`timescale 1ns/1ps
module qpm_far_side (
   input wire logic clock,
   input wire logic [31:0] ext_drv,   // Far side drives these pins
   input wire logic [31:0] ext_val,   // Levels it drives
   input wire logic [31:0] pins_out,
   input wire logic [31:0] pins_oe,
   output logic [31:0] pins_in
);
   logic [31:0] float_lvl = 32'h0;    // Level of unattended pins
   // Released pins show the inverse of their last driven level
   always_ff @(posedge clock) begin
      for (int i = 0; i < 32; i++) begin
         if (pins_oe[i] === 1'b1 || ext_drv[i] === 1'b1) begin
            float_lvl[i] <= ~pins_in[i];
         end
      end
   end
   // Wire level from every driver, float level where nothing drives
   assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext_drv & ext_val) |
      (~pins_oe & ~ext_drv & float_lvl);
endmodule

// ===== testbench/qpm_top_tb.sv
// Self-checking bench for the pin function multiplexer.
// Assumes the register map of the package and a single AXI4-Lite master.
`timescale 1ns/1ps
module qpm_top_tb import qpm_pkg::*;;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awa = 8'h00;           // Write address
   logic [7:0] ara = 8'h00;           // Read address
   logic [31:0] wd = 32'h0;           // Write data
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic susp = 1'b0;                 // Host link suspended
   logic [31:0] ext_drv = 32'h0, ext_val = 32'h0;
   logic awr, wrdy, bv, arr, rv, resume;
   logic [1:0] br, rr;
   logic [31:0] rd, pin_in, pin_out, pin_oe;
   int num_errors = 0;
   int total_checks = 0;
   qpm_top DUT (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .chan_a_pins_in(pin_in[7:0]), .chan_a_pins_out(pin_out[7:0]),
      .chan_a_pins_oe(pin_oe[7:0]), .chan_b_pins_in(pin_in[15:8]),
      .chan_b_pins_out(pin_out[15:8]), .chan_b_pins_oe(pin_oe[15:8]),
      .chan_c_pins_in(pin_in[23:16]), .chan_c_pins_out(pin_out[23:16]),
      .chan_c_pins_oe(pin_oe[23:16]), .chan_d_pins_in(pin_in[31:24]),
      .chan_d_pins_out(pin_out[31:24]), .chan_d_pins_oe(pin_oe[31:24]),
      .usb_suspended(susp), .resume_request(resume));
   qpm_far_side u_far (.clock(clock), .ext_drv(ext_drv), .ext_val(ext_val),
      .pins_out(pin_out), .pins_oe(pin_oe), .pins_in(pin_in));
   // 25 MHz clock
   always #20 clock = ~clock;
   // Compare one value
   task automatic chk(input logic [31:0] e, input logic [31:0] g, input string m);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: %s exp %h got %h", $time, m, e, g);
      end
   endtask
   // AXI write, bready raised with the request and held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad = 1'b0;
      logic dd = 1'b0;
      @(posedge clock);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge clock);
         ad = ad || awr;
         dd = dd || wrdy;
         awv <= !ad;
         wv <= !dd;
      end
      do @(posedge clock); while (!bv);
      r = br;
      bre <= 1'b0;
   endtask
   // AXI read, rready held from the request until rvalid
   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do @(posedge clock); while (!arr);
      arv <= 1'b0;
      do @(posedge clock); while (!rv);
      d = rd;
      r = rr;
      rre <= 1'b0;
   endtask
   // Write expecting a plain response
   task automatic cfg(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk({30'h0, QPM_RESP_OKAY}, {30'h0, r}, "write response");
   endtask
   // Read and compare the masked word
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input string s);
      logic [31:0] d;
      logic [1:0] r;
      rdr(a, d, r);
      chk(e, d & m, s);
   endtask
   // Far side levels
   task automatic drive(input logic [31:0] m, input logic [31:0] v);
      @(posedge clock);
      ext_drv <= m;
      ext_val <= v;
   endtask
   // Pins and synchronisers catch up
   task automatic settle;
      repeat (5) @(posedge clock);
   endtask
   task automatic t_reset;
      rchk(QPM_OFF_MODE, 32'hFFFFFFFF, 32'h0, "mode reset");
      rchk(QPM_OFF_STATUS, 32'hFFFF, 32'h1111, "blank modes");
      chk(32'h15151515, pin_oe, "serial roles");
      $display("test reset done");
   endtask
   task automatic t_serial;
      drive(32'hEA, 32'hA2);
      cfg(QPM_OFF_OUT_AB, 32'h0000FFFF);
      settle;
      rchk(QPM_OFF_PIN_IN, 32'hEA, 32'hA2, "serial inputs");
      chk(32'h00001515, pin_out, "serial outputs");
      $display("test serial done");
   endtask
   task automatic t_driver;
      drive(32'h6A, 32'h22);
      cfg(QPM_OFF_MODE, 32'h00010100);
      settle;
      chk(32'h15151595, pin_oe, "driver enable role");
      chk(32'h00001595, pin_out, "driver enable level");
      cfg(QPM_OFF_MODE, 32'h00000100);
      settle;
      chk(32'h15151515, pin_oe, "blank gives ring input");
      $display("test driver done");
   endtask
   task automatic t_bitbang;
      cfg(QPM_OFF_OUT_AB, 32'h0000FF00);
      cfg(QPM_OFF_DIR_AB, 32'h00005A00);
      drive(32'h0000A500, 32'h00008100);
      for (int c = 1; c <= 2; c++) begin
         cfg(QPM_OFF_MODE, 32'h00010000 | 32'(c << 2));
         settle;
         chk(32'h15155A15, pin_oe, "bitbang roles");
         chk(32'h00005A00, pin_out, "bitbang drive");
         rchk(QPM_OFF_PIN_IN, 32'h0000A500, 32'h00008100, "bitbang inputs");
         rchk(QPM_OFF_STATUS, 32'hFFFF, (c == 1) ? 32'h1121 : 32'h1141, "bitbang mode");
      end
      $display("test bitbang done");
   endtask
   task automatic t_engine;
      cfg(QPM_OFF_DIR_AB, 32'h000030A5);
      cfg(QPM_OFF_DIR_CD, 32'h00003CFF);
      cfg(QPM_OFF_OUT_AB, 32'h000000F0);
      drive(32'h4, 32'h4);
      cfg(QPM_OFF_MODE, 32'h0001007F);
      settle;
      chk(32'h3C153BAB, pin_oe, "engine roles");
      chk(32'h000000A0, pin_out, "general lines");
      rchk(QPM_OFF_PIN_IN, 32'h4, 32'h4, "engine data in");
      rchk(QPM_OFF_STATUS, 32'hFFFF, 32'h2188, "engine modes");
      $display("test engine done");
   endtask
   task automatic t_resume;
      cfg(QPM_OFF_MODE, 32'h00011000);
      drive(32'h80808080, 32'h80808000);
      susp <= 1'b1;
      settle;
      chk(32'h1, {31'h0, resume}, "resume request");
      drive(32'h80808080, 32'h80808080);
      settle;
      chk(32'h0, {31'h0, resume}, "ring released");
      cfg(QPM_OFF_MODE, 32'h00010000);
      drive(32'h80808080, 32'h80808000);
      settle;
      chk(32'h0, {31'h0, resume}, "wakeup disabled");
      susp <= 1'b0;
      $display("test resume done");
   endtask
   task automatic t_unmapped;
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h1C, 32'hFFFFFFFF, r);
      chk({30'h0, QPM_RESP_SLVERR}, {30'h0, r}, "unmapped write");
      rdr(8'h1C, d, r);
      chk({30'h0, QPM_RESP_SLVERR}, {30'h0, r}, "unmapped read");
      chk(32'h0, d, "unmapped data");
      $display("test unmapped done");
   endtask
   // Counts and verdict
   task automatic results;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset;
      t_serial;
      t_driver;
      t_bitbang;
      t_engine;
      t_resume;
      t_unmapped;
      results;
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      results;
   end
endmodule
